// [hdl/hsp_host.sv]
// What this block does
// - The host drives serial clock, serial data in and active-low chip select.
// - Host opens and closes every transaction; command word first, then data words.
// - Command word is 16 bits, MSB first: read/write, address step, 12-bit address.
// - Spare command bits are ignored; host sends them as zero.
// - Without address step, host sends exactly one data word per command.
// - Read/write bit high starts a read, low starts a write.
// - Data words move MSB first, timed to the rising serial clock edge.
// - During a read only one chained device may have chip select asserted.
// - Write gap between command and data depends on video clock rate.
// - Same write gap between write sequences and between stepped data words.
// - Read gap after command before data clocks depends on video clock rate.
// - Chip select stays low after last rising edge for a rate-dependent time.
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
module hsp_host
	import hsp_pkg::*;
#(
	parameter int NUM_SEL = 1
) (
	// Clock and reset.
	input  wire logic               aclk,
	input  wire logic               aresetn,
	// AXI4-Lite slave.
	input  wire logic [7:0]         s_awaddr,
	input  wire logic               s_awvalid,
	output logic                    s_awready,
	input  wire logic [31:0]        s_wdata,
	input  wire logic [3:0]         s_wstrb,
	input  wire logic               s_wvalid,
	output logic                    s_wready,
	output logic [1:0]              s_bresp,
	output logic                    s_bvalid,
	input  wire logic               s_bready,
	input  wire logic [7:0]         s_araddr,
	input  wire logic               s_arvalid,
	output logic                    s_arready,
	output logic [31:0]             s_rdata,
	output logic [1:0]              s_rresp,
	output logic                    s_rvalid,
	input  wire logic               s_rready,
	// Serial port pins.
	output logic                    serial_clk,
	output logic                    serial_data_in,
	output logic [NUM_SEL-1:0]      chip_sel_n,
	input  wire logic               serial_data_thru_out,
	output logic                    port_select_test
);

	// The select mask register has eight bits, so at most eight selects.
	if (NUM_SEL < 1 || NUM_SEL > 8) begin
		$error("NUM_SEL must be 1 to 8");
	end
	// Gap counters must hold the longest wait, and the shifters are one word wide.
	if (HOLD_UNL_CYC >= 2**GAP_W || RGAP_UNL_CYC >= 2**GAP_W || WORD_W != 16) begin
		$error("Gap counter too narrow or word width not 16");
	end

	typedef enum logic [2:0] {
		HSP_IDLE,
		HSP_SETUP,
		HSP_SHIFT,
		HSP_GAP,
		HSP_WAIT,
		HSP_HOLD
	} hsp_state_e;

	typedef struct packed {
		hsp_state_e  state;
		logic        sclk;
		logic        sdo;
		logic        cs_n_act;
		logic [15:0] shreg;
		logic [15:0] rxreg;
		logic [4:0]  bitcnt;
		logic [7:0]  divcnt;
		logic        in_cmd;
		logic        is_read;
		logic        step;
		logic        last;
		logic [15:0] rdata;
		logic [GAP_W-1:0] gapcnt;
		logic [15:0] words;
		logic        busy;
		logic        sdo_s1;
		logic        sdo_s2;
		logic [NUM_SEL-1:0] sel_mask;
	} hsp_host_s;

	hsp_host_s st;
	hsp_host_s next_st;

	logic [31:0] ctrl;
	logic [15:0] cmd_word;
	logic [15:0] wdata_word;
	logic        go_pulse;
	logic [31:0] status;
	hsp_rate_e   rate;
	logic [7:0]  clkdiv;

	hsp_axil_regs u_regs (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.s_awaddr   (s_awaddr),
		.s_awvalid  (s_awvalid),
		.s_awready  (s_awready),
		.s_wdata    (s_wdata),
		.s_wstrb    (s_wstrb),
		.s_wvalid   (s_wvalid),
		.s_wready   (s_wready),
		.s_bresp    (s_bresp),
		.s_bvalid   (s_bvalid),
		.s_bready   (s_bready),
		.s_araddr   (s_araddr),
		.s_arvalid  (s_arvalid),
		.s_arready  (s_arready),
		.s_rdata    (s_rdata),
		.s_rresp    (s_rresp),
		.s_rvalid   (s_rvalid),
		.s_rready   (s_rready),
		.ctrl       (ctrl),
		.cmd_word   (cmd_word),
		.wdata_word (wdata_word),
		.go_pulse   (go_pulse),
		.rdata_word (st.rdata),
		.status     (status)
	);

	assign rate   = hsp_rate_e'(ctrl[CTRL_RATE_LSB +: 2]);
	// A half period of zero is served as one; the divider would also toggle every cycle.
	assign clkdiv = (ctrl[CTRL_CLKDIV_LSB +: 8] == 8'h0) ? 8'h01 : ctrl[CTRL_CLKDIV_LSB +: 8];

	// Gaps are whole cycles rounded up, so each one errs on the long side.
	function automatic logic [GAP_W-1:0] gap_cycles(input logic rd, input hsp_rate_e r);
		logic [GAP_W-1:0] g;
		g = GAP_W'(1);
		unique case (r)
			HSP_RATE_UNLOCKED: g = rd ? GAP_W'(RGAP_UNL_CYC) : GAP_W'(WGAP_UNL_CYC);
			HSP_RATE_27:       g = rd ? GAP_W'(RGAP_27_CYC)  : GAP_W'(WGAP_27_CYC);
			HSP_RATE_74:       g = rd ? GAP_W'(RGAP_74_CYC)  : GAP_W'(WGAP_74_CYC);
			HSP_RATE_148:      g = rd ? GAP_W'(RGAP_148_CYC) : GAP_W'(WGAP_148_CYC);
		endcase
		return g;
	endfunction

	function automatic logic [GAP_W-1:0] hold_cycles(input hsp_rate_e r);
		logic [GAP_W-1:0] g;
		g = GAP_W'(1);
		unique case (r)
			HSP_RATE_UNLOCKED: g = GAP_W'(HOLD_UNL_CYC);
			HSP_RATE_27:       g = GAP_W'(HOLD_27_CYC);
			HSP_RATE_74:       g = GAP_W'(HOLD_74_CYC);
			HSP_RATE_148:      g = GAP_W'(HOLD_148_CYC);
		endcase
		return g;
	endfunction

	// Status: busy, controller not idle, words sent.
	assign status = {st.words, 14'h0, st.state != HSP_IDLE, st.busy};

	always_comb begin
		next_st = st;
		// Loop-back data from the device is a pin: two flip-flops before use.
		next_st.sdo_s1 = serial_data_thru_out;
		next_st.sdo_s2 = st.sdo_s1;
		unique case (st.state)
			HSP_IDLE: begin
				// GO is heard only here, so one sent mid-transfer is dropped.
				if (go_pulse) begin
					next_st.busy    = 1'b1;
					next_st.last    = ctrl[CTRL_LAST_BIT];
					next_st.divcnt  = 8'h0;
					next_st.bitcnt  = 5'h0;
					next_st.sclk    = 1'b0;
					if (!st.cs_n_act) begin
						// Fresh transaction always opens with a command word.
						next_st.sel_mask = NUM_SEL'(ctrl[31:24]);
						if (cmd_word[CMD_RW_BIT]) begin
							// A read may pull only one select low; the lowest is kept.
							next_st.sel_mask &= ~next_st.sel_mask + NUM_SEL'(1);
						end
						next_st.cs_n_act = 1'b1;
						next_st.in_cmd   = 1'b1;
						// Spare bits forced to zero.
						next_st.shreg    = {cmd_word[15], 2'b00, cmd_word[12:0]};
						next_st.is_read  = cmd_word[CMD_RW_BIT];
						next_st.step     = cmd_word[CMD_STEP_BIT];
						next_st.gapcnt   = GAP_W'(1);
						next_st.state    = HSP_SETUP;
					end else begin
						// Stepped write words follow after the write gap.
						next_st.in_cmd = 1'b0;
						next_st.shreg  = wdata_word;
						next_st.gapcnt = gap_cycles(st.is_read, rate);
						next_st.state  = HSP_SETUP;
					end
				end
			end
			HSP_SETUP: begin
				// Chip select low well before the first rising edge; data leads the edge.
				next_st.sdo = st.shreg[15];
				if (st.gapcnt <= GAP_W'(1)) begin
					next_st.state = HSP_SHIFT;
				end else begin
					next_st.gapcnt = st.gapcnt - GAP_W'(1);
				end
			end
			HSP_SHIFT: begin
				// The clock toggles only inside a word, half period each clkdiv cycles.
				if (st.divcnt + 8'h1 >= clkdiv) begin
					next_st.divcnt = 8'h0;
					next_st.sclk   = !st.sclk;
					if (!st.sclk) begin
						// The synchroniser lags two cycles, so half periods under three read stale bits.
						// Rising edge: capture loop-back data, MSB first.
						next_st.rxreg  = {st.rxreg[14:0], st.sdo_s2};
						next_st.bitcnt = st.bitcnt + 5'h1;
					end else begin
						// Falling edge: present next bit, or finish the word.
						next_st.shreg = {st.shreg[14:0], 1'b0};
						next_st.sdo   = st.shreg[14];
						if (st.bitcnt == 5'(WORD_W)) begin
							next_st.bitcnt = 5'h0;
							next_st.sdo    = 1'b0;
							next_st.state  = HSP_GAP;
							next_st.gapcnt = st.in_cmd ? gap_cycles(st.is_read, rate)
								: hold_cycles(rate);
						end
					end
				end else begin
					next_st.divcnt = st.divcnt + 8'h1;
				end
			end
			HSP_GAP: begin
				// Clock idles low through the gap after every word.
				if (st.gapcnt <= GAP_W'(1)) begin
					if (st.in_cmd) begin
						// One data word follows the command per GO; further stepped words need another GO.
						next_st.in_cmd = 1'b0;
						next_st.shreg  = st.is_read ? 16'h0 : wdata_word;
						next_st.sdo    = st.is_read ? 1'b0 : wdata_word[15];
						next_st.state  = HSP_SHIFT;
					end else begin
						next_st.words = st.words + 16'h1;
						if (st.is_read) begin
							next_st.rdata = st.rxreg;
						end
						next_st.state = HSP_HOLD;
					end
				end else begin
					next_st.gapcnt = st.gapcnt - GAP_W'(1);
				end
			end
			HSP_HOLD: begin
				// Hold time already spent in the gap; close on the last word, on a read, or without step.
				// The step bit is kept from the command, so a new CMD load cannot cut a burst.
				if (st.last || st.is_read || !st.step) begin
					next_st.cs_n_act = 1'b0;
					next_st.gapcnt   = gap_cycles(1'b0, rate);
					next_st.state    = HSP_WAIT;
				end else begin
					next_st.busy  = 1'b0;
					next_st.state = HSP_IDLE;
				end
			end
			HSP_WAIT: begin
				// Write gap also spaces back-to-back transactions.
				if (st.gapcnt <= GAP_W'(1)) begin
					next_st.busy  = 1'b0;
					next_st.state = HSP_IDLE;
				end else begin
					next_st.gapcnt = st.gapcnt - GAP_W'(1);
				end
			end
			default: next_st.state = HSP_IDLE;
		endcase
	end

	// Reset clears the mask, so every select idles high.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign serial_clk     = st.sclk;
	assign serial_data_in = st.sdo;
	// Only one select is low during a read, as the mask is cut at the command.
	assign chip_sel_n     = ~(st.sel_mask & {NUM_SEL{st.cs_n_act}});
	// The select pin follows the register at once; flip it only while idle.
	assign port_select_test = ctrl[CTRL_SEL_BIT];

endmodule

// [hdl/hsp_pkg.sv]
package hsp_pkg;

	// AXI4-Lite register offsets of the controller.
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_CMD    = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_RDATA  = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;

	// Control register fields.
	localparam int CTRL_GO_BIT      = 0;
	localparam int CTRL_LAST_BIT    = 1;
	localparam int CTRL_SEL_BIT     = 2;
	localparam int CTRL_RATE_LSB    = 4;
	localparam int CTRL_CLKDIV_LSB  = 8;

	// Command word layout.
	localparam int CMD_RW_BIT       = 15;
	localparam int CMD_STEP_BIT     = 12;
	localparam int CMD_ADDR_W       = 12;
	localparam int WORD_W           = 16;

	// Reset values.
	localparam logic [7:0] CLKDIV_RST = 8'h01;
	localparam logic [1:0] RATE_RST   = 2'h0;

	// Video clock rate codes that pick the wait gaps.
	typedef enum logic [1:0] {
		HSP_RATE_UNLOCKED,
		HSP_RATE_27,
		HSP_RATE_74,
		HSP_RATE_148
	} hsp_rate_e;

	localparam int CLK_PERIOD_PS = 8000;

	// Gaps in picoseconds as printed, turned into cycles rounded up.
	localparam int WGAP_UNL_PS  = 100000;
	localparam int WGAP_27_PS   = 37100;
	localparam int WGAP_74_PS   = 13500;
	localparam int WGAP_148_PS  = 6700;
	localparam int RGAP_UNL_PS  = 222600;
	localparam int RGAP_27_PS   = 148400;
	localparam int RGAP_74_PS   = 53900;
	localparam int RGAP_148_PS  = 27000;
	localparam int HOLD_UNL_PS  = 445000;
	localparam int HOLD_27_PS   = 37100;
	localparam int HOLD_74_PS   = 13500;
	localparam int HOLD_148_PS  = 6700;

	localparam int WGAP_UNL_CYC = (WGAP_UNL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WGAP_27_CYC  = (WGAP_27_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WGAP_74_CYC  = (WGAP_74_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WGAP_148_CYC = (WGAP_148_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RGAP_UNL_CYC = (RGAP_UNL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RGAP_27_CYC  = (RGAP_27_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RGAP_74_CYC  = (RGAP_74_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RGAP_148_CYC = (RGAP_148_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int HOLD_UNL_CYC = (HOLD_UNL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int HOLD_27_CYC  = (HOLD_27_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int HOLD_74_CYC  = (HOLD_74_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int HOLD_148_CYC = (HOLD_148_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	localparam int GAP_W = 7;

endpackage

// [hdl/hsp_axil_regs.sv]
module hsp_axil_regs
	import hsp_pkg::*;
(
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave.
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	// Controller side.
	output logic [31:0]      ctrl,
	output logic [15:0]      cmd_word,
	output logic [15:0]      wdata_word,
	output logic             go_pulse,
	input  wire logic [15:0] rdata_word,
	input  wire logic [31:0] status
);

	typedef struct packed {
		logic        aw_got;
		logic [7:0]  awaddr;
		logic        w_got;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [31:0] ctrl;
		logic [15:0] cmd;
		logic [15:0] wd;
		logic        go;
	} hsp_regs_s;

	hsp_regs_s st;
	hsp_regs_s next_st;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Write address and data are taken independently; the response waits for both.
	assign s_awready = !st.aw_got && !st.bvalid;
	assign s_wready  = !st.w_got && !st.bvalid;
	assign s_arready = !st.rvalid;

	always_comb begin
		next_st = st;
		next_st.go = 1'b0;
		if (s_awvalid && s_awready) begin
			next_st.aw_got = 1'b1;
			next_st.awaddr = s_awaddr;
		end
		if (s_wvalid && s_wready) begin
			next_st.w_got = 1'b1;
			next_st.wdata = s_wdata;
			next_st.wstrb = s_wstrb;
		end
		if (st.aw_got && st.w_got) begin
			next_st.aw_got = 1'b0;
			next_st.w_got  = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp  = 2'h0;
			unique case ({st.awaddr[7:2], 2'h0})
				REG_CTRL: begin
					next_st.ctrl = merge(st.ctrl, st.wdata, st.wstrb);
					next_st.go   = st.wstrb[0] && st.wdata[CTRL_GO_BIT];
					next_st.ctrl[CTRL_GO_BIT] = 1'b0;
				end
				REG_CMD:    next_st.cmd = 16'(merge({16'h0, st.cmd}, st.wdata, st.wstrb));
				REG_WDATA:  next_st.wd  = 16'(merge({16'h0, st.wd}, st.wdata, st.wstrb));
				REG_RDATA, REG_STATUS: next_st.bresp = 2'h2;
				default:    next_st.bresp = 2'h2;
			endcase
		end
		if (st.bvalid && s_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (s_arvalid && s_arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = 2'h0;
			unique case ({s_araddr[7:2], 2'h0})
				REG_CTRL:   next_st.rdata = st.ctrl;
				REG_CMD:    next_st.rdata = {16'h0, st.cmd};
				REG_WDATA:  next_st.rdata = {16'h0, st.wd};
				REG_RDATA:  next_st.rdata = {16'h0, rdata_word};
				REG_STATUS: next_st.rdata = status;
				default: begin
					next_st.rdata = 32'h0;
					next_st.rresp = 2'h2;
				end
			endcase
		end else if (st.rvalid && s_rready) begin
			next_st.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st      <= '0;
			st.ctrl <= {16'h0, CLKDIV_RST, 2'h0, RATE_RST, 4'h0};
		end else begin
			st <= next_st;
		end
	end

	assign s_bvalid   = st.bvalid;
	assign s_bresp    = st.bresp;
	assign s_rvalid   = st.rvalid;
	assign s_rdata    = st.rdata;
	assign s_rresp    = st.rresp;
	assign ctrl       = st.ctrl;
	assign cmd_word   = st.cmd;
	assign wdata_word = st.wd;
	assign go_pulse   = st.go;

endmodule

// [verif/hsp_host_props.sv]
module hsp_host_props
	import hsp_pkg::*;
#(
	parameter int NUM_SEL = 1
) (
	// Clock and reset.
	input wire logic               aclk,
	input wire logic               aresetn,
	// Register bus.
	input wire logic [7:0]         s_awaddr,
	input wire logic               s_awvalid,
	input wire logic               s_awready,
	input wire logic [31:0]        s_wdata,
	input wire logic               s_wvalid,
	input wire logic               s_wready,
	input wire logic               s_bvalid,
	input wire logic               s_bready,
	input wire logic               s_rvalid,
	input wire logic               s_rready,
	// Serial port pins.
	input wire logic               serial_clk,
	input wire logic               serial_data_in,
	input wire logic [NUM_SEL-1:0] chip_sel_n,
	input wire logic               port_select_test
);
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [11:0] bits;
		logic [7:0]  low;
		logic [7:0]  since;
		logic        prev;
		logic        rw;
		logic [1:0]  rate;
		logic        sel;
	} hsp_mon_s;
	localparam int WG [4] = '{WGAP_UNL_CYC, WGAP_27_CYC, WGAP_74_CYC, WGAP_148_CYC};
	localparam int RG [4] = '{RGAP_UNL_CYC, RGAP_27_CYC, RGAP_74_CYC, RGAP_148_CYC};
	localparam int HG [4] = '{HOLD_UNL_CYC, HOLD_27_CYC, HOLD_74_CYC, HOLD_148_CYC};
	hsp_mon_s st;
	hsp_mon_s next_st;
	// The rate is snooped from register writes, since the pins alone do not carry it.
	always_comb begin
		next_st = st;
		next_st.prev = serial_clk;
		next_st.low = serial_clk ? 8'h00 : ((st.low == 8'hff) ? st.low : st.low + 8'h01);
		next_st.since = (st.since == 8'hff) ? st.since : st.since + 8'h01;
		if (serial_clk && !st.prev) begin
			next_st.since = 8'h01;
			next_st.bits = st.bits + 12'h001;
			if (st.bits == 12'h000) begin
				next_st.rw = serial_data_in;
			end
		end
		if (chip_sel_n[0]) begin
			next_st.bits = 12'h000;
		end
		if (s_awvalid && s_awready && s_wvalid && s_wready && s_awaddr == REG_CTRL) begin
			next_st.rate = s_wdata[CTRL_RATE_LSB +: 2];
			next_st.sel = s_wdata[CTRL_SEL_BIT];
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_awvalid && s_awready && s_wvalid && s_wready;
	endsequence
	sequence s_ctrl_wr;
		s_wr_taken ##0 s_awaddr == REG_CTRL;
	endsequence
	sequence s_word_start;
		$rose(serial_clk) && st.bits != 12'h000 && st.bits[3:0] == 4'h0;
	endsequence
	property p_clk_in_frame;
		serial_clk |-> !chip_sel_n[0];
	endproperty
	a_clk_in_frame: assert property (p_clk_in_frame) else $error("clock outside frame");
	property p_cs_setup;
		$rose(serial_clk) |-> $past(chip_sel_n[0]) == 1'b0;
	endproperty
	a_cs_setup: assert property (p_cs_setup) else $error("select too late");
	property p_sdi_setup;
		$rose(serial_clk) |-> $stable(serial_data_in);
	endproperty
	a_sdi_setup: assert property (p_sdi_setup) else $error("data moved at rise");
	property p_word_gap;
		s_word_start |-> st.low >= (st.rw ? RG[st.rate] : WG[st.rate]);
	endproperty
	a_word_gap: assert property (p_word_gap) else $error("word gap short");
	property p_cs_hold;
		$rose(chip_sel_n[0]) |-> st.since >= HG[st.rate];
	endproperty
	a_cs_hold: assert property (p_cs_hold) else $error("select hold short");
	property p_word_len;
		$rose(chip_sel_n[0]) |-> st.bits >= 12'h020 && st.bits[3:0] == 4'h0;
	endproperty
	a_word_len: assert property (p_word_len) else $error("partial frame");
	property p_sel_pin;
		s_ctrl_wr |=> ##[1:2] port_select_test == st.sel;
	endproperty
	a_sel_pin: assert property (p_sel_pin) else $error("port select pin wrong");
	property p_wr_resp;
		s_wr_taken |-> ##[1:3] s_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("no write response");
	property p_resp_hold;
		(s_bvalid && !s_bready |=> s_bvalid) and (s_rvalid && !s_rready |=> s_rvalid);
	endproperty
	a_resp_hold: assert property (p_resp_hold) else $error("response dropped");
endmodule

// [verif/hsp_dev_model.sv]
module hsp_dev_model (
	// Serial port pins.
	input  wire logic serial_clk,
	input  wire logic serial_data_in,
	input  wire logic chip_sel_n,
	input  wire logic port_select_test,
	output logic      serial_data_thru_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:4095];
	logic [15:0] sh;
	logic [15:0] cmd;
	logic [15:0] rd_sh;
	logic [11:0] addr;
	logic [4:0]  nbit = 5'h00;
	logic        have_cmd = 1'b0;
	logic        rd_on;
	always @(posedge serial_clk or posedge chip_sel_n) begin
		if (chip_sel_n || port_select_test) begin
			nbit = 5'h00;
			have_cmd = 1'b0;
		end else begin
			sh = {sh[14:0], serial_data_in};
			nbit = nbit + 5'h01;
			if (nbit == 5'h10) begin
				nbit = 5'h00;
				if (!have_cmd) begin
					have_cmd = 1'b1;
					cmd = sh;
					addr = sh[11:0];
				end else if (!cmd[15]) begin
					mem[addr] = sh;
					addr = cmd[12] ? addr + 12'h001 : addr;
				end
			end
		end
	end
	assign rd_on = !chip_sel_n && have_cmd && cmd[15];
	always @(negedge serial_clk) begin
		if (rd_on) begin
			rd_sh = (nbit == 5'h00) ? mem[addr] : {rd_sh[14:0], 1'b0};
		end
	end
	// Unclocked loop-through, so a chained part sees each bit with gate delay only.
	assign serial_data_thru_out = port_select_test ? ~serial_data_in :
		(rd_on ? rd_sh[15] : serial_data_in);
endmodule

// [verif/hsp_host_tb.sv]
module hsp_host_tb
	import hsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_awaddr = 8'h00;
	logic [7:0]  s_araddr = 8'h00;
	logic [31:0] s_wdata = 32'h0;
	logic [3:0]  s_wstrb = 4'hf;
	logic        s_awvalid = 1'b0;
	logic        s_wvalid = 1'b0;
	logic        s_bready = 1'b0;
	logic        s_arvalid = 1'b0;
	logic        s_rready = 1'b0;
	logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0]  s_bresp, s_rresp, resp;
	logic [31:0] s_rdata, rdv;
	logic        serial_clk, serial_data_in, serial_data_thru_out, port_select_test;
	logic [0:0]  chip_sel_n;
	int          fails = 0;
	int          num_checks = 0;
	int          cycles = 0;
	hsp_host #(.NUM_SEL(1)) DUT (
		.aclk                 (aclk),
		.aresetn              (aresetn),
		.s_awaddr             (s_awaddr),
		.s_awvalid            (s_awvalid),
		.s_awready            (s_awready),
		.s_wdata              (s_wdata),
		.s_wstrb              (s_wstrb),
		.s_wvalid             (s_wvalid),
		.s_wready             (s_wready),
		.s_bresp              (s_bresp),
		.s_bvalid             (s_bvalid),
		.s_bready             (s_bready),
		.s_araddr             (s_araddr),
		.s_arvalid            (s_arvalid),
		.s_arready            (s_arready),
		.s_rdata              (s_rdata),
		.s_rresp              (s_rresp),
		.s_rvalid             (s_rvalid),
		.s_rready             (s_rready),
		.serial_clk           (serial_clk),
		.serial_data_in       (serial_data_in),
		.chip_sel_n           (chip_sel_n),
		.serial_data_thru_out (serial_data_thru_out),
		.port_select_test     (port_select_test)
	);
	hsp_dev_model u_dev (
		.serial_clk           (serial_clk),
		.serial_data_in       (serial_data_in),
		.chip_sel_n           (chip_sel_n[0]),
		.port_select_test     (port_select_test),
		.serial_data_thru_out (serial_data_thru_out)
	);
	always #4 aclk = ~aclk;
	task automatic end_of_test();
		if (fails == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// The whole run needs a few thousand cycles; the ceiling leaves a wide margin.
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fails++;
			end_of_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_awvalid && s_awready) s_awvalid <= 1'b0;
			if (s_wvalid && s_wready) s_wvalid <= 1'b0;
			if (s_bvalid) begin
				resp = s_bresp;
				s_bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_arvalid && s_arready) s_arvalid <= 1'b0;
			if (s_rvalid) begin
				rdv = s_rdata;
				resp = s_rresp;
				s_rready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic wait_done(input int b);
		do rd(REG_STATUS); while (rdv[b] !== 1'b1);
		do rd(REG_STATUS); while (rdv[b] !== 1'b0);
	endtask
	function automatic logic [31:0] ctl(input logic [1:0] rt, input logic sel, input logic last);
		return 32'h0100_0300 | {26'h0, rt, 1'b0, sel, last, 1'b1};
	endfunction
	task automatic t_regs();
		rd(REG_CTRL);
		chk("ctrl_reset", 32'h0000_0100, {16'h0, rdv[15:0]});
		s_araddr <= REG_CTRL;
		s_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_arready);
		s_arvalid <= 1'b0;
		repeat (3) @(posedge aclk);
		chk("rvalid_stands", 32'h1, {31'h0, s_rvalid});
		chk("rdata_stands", 32'h0000_0100, s_rdata);
		s_rready <= 1'b1;
		do @(posedge aclk); while (!s_rvalid);
		s_rready <= 1'b0;
		rd(REG_STATUS);
		chk("status_reset", 32'h0, rdv);
		chk("idle_pins", 32'h1, {30'h0, serial_clk, chip_sel_n[0]});
		rd(8'h14);
		chk("unmapped_resp", 32'h2, {30'h0, resp});
		wr(REG_STATUS, 32'hffff_ffff);
		chk("ro_resp", 32'h2, {30'h0, resp});
		wr(REG_CTRL, 32'h0000_0304);
		chk("sel_high", 32'h1, {31'h0, port_select_test});
		wr(REG_CTRL, 32'h0000_0300);
		chk("sel_low", 32'h0, {31'h0, port_select_test});
	endtask
	task automatic t_xfer(input logic [1:0] rt);
		logic [11:0] a;
		logic [15:0] v;
		a = 12'h100 + {10'h0, rt};
		v = 16'ha5c3 ^ {14'h0, rt};
		wr(REG_CMD, {16'h0, 4'h0, a});
		wr(REG_WDATA, {16'h0, v});
		wr(REG_CTRL, ctl(rt, 1'b0, 1'b1));
		wait_done(1);
		chk("device_word", {16'h0, v}, {16'h0, u_dev.mem[a]});
		wr(REG_CMD, {16'h0, 4'h8, a});
		wr(REG_CTRL, ctl(rt, 1'b0, 1'b1));
		wait_done(1);
		rd(REG_RDATA);
		chk("read_word", {16'h0, v}, {16'h0, rdv[15:0]});
	endtask
	task automatic t_step();
		wr(REG_CMD, 32'h0000_7200);
		for (int i = 0; i < 3; i++) begin
			wr(REG_WDATA, 32'h1230 + i);
			wr(REG_CTRL, ctl(2'h3, 1'b0, 1'(i == 2)));
			wait_done((i == 2) ? 1 : 0);
		end
		for (int i = 0; i < 3; i++) begin
			chk("step_word", 32'h1230 + i, {16'h0, u_dev.mem[12'h200 + i]});
		end
		rd(REG_STATUS);
		chk("words_done", 32'h000b_0000, rdv);
	endtask
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		for (int r = 0; r < 4; r++) begin
			t_xfer(2'(r));
		end
		t_step();
		end_of_test();
	end
endmodule
bind hsp_host hsp_host_props #(.NUM_SEL(NUM_SEL)) u_props (
	.aclk             (aclk),
	.aresetn          (aresetn),
	.s_awaddr         (s_awaddr),
	.s_awvalid        (s_awvalid),
	.s_awready        (s_awready),
	.s_wdata          (s_wdata),
	.s_wvalid         (s_wvalid),
	.s_wready         (s_wready),
	.s_bvalid         (s_bvalid),
	.s_bready         (s_bready),
	.s_rvalid         (s_rvalid),
	.s_rready         (s_rready),
	.serial_clk       (serial_clk),
	.serial_data_in   (serial_data_in),
	.chip_sel_n       (chip_sel_n),
	.port_select_test (port_select_test)
);
